/* gnp_pkg.sv */
// constants of the next-page and gigabit master/slave management registers
// assumes a 5-bit register address and 16-bit register data from the management front end
`default_nettype none
package gnp_pkg;

    typedef logic [4:0] gnp_addr_t;
    typedef logic [15:0] gnp_word_t;

    // register offsets
    localparam gnp_addr_t GNP_OFS_NP_TX = 5'h07;
    localparam gnp_addr_t GNP_OFS_NP_RX = 5'h08;
    localparam gnp_addr_t GNP_OFS_GCTRL = 5'h09;
    localparam gnp_addr_t GNP_OFS_GSTAT = 5'h0A;
    localparam gnp_addr_t GNP_OFS_EXTST = 5'h0F;

    // reset values
    localparam gnp_word_t GNP_RST_NP_TX = 16'h2001;
    localparam gnp_word_t GNP_RST_NP_RX = 16'h0000;
    localparam gnp_word_t GNP_RST_GCTRL = 16'h0200;
    localparam gnp_word_t GNP_VAL_EXTST = 16'h3000;

    // next page field positions (both page registers)
    localparam int GNP_NP_MORE = 15;
    localparam int GNP_NP_ACK = 14;
    localparam int GNP_NP_MSG = 13;
    localparam int GNP_NP_COMPLY = 12;
    localparam int GNP_NP_FLIP = 11;
    localparam int GNP_NP_CODE_W = 11;

    // gigabit control field positions
    localparam int GNP_GC_TEST_HI = 15;
    localparam int GNP_GC_TEST_LO = 13;
    localparam int GNP_GC_MS_MANUAL = 12;
    localparam int GNP_GC_MS_MASTER = 11;
    localparam int GNP_GC_MULTIPORT = 10;
    localparam int GNP_GC_ADV_FULL = 9;
    localparam int GNP_GC_ADV_HALF = 8;

    // test mode codes
    typedef enum logic [2:0] {
        GNP_TM_NORMAL = 3'h0,
        GNP_TM_WAVEFORM = 3'h1,
        GNP_TM_MASTER_JITTER = 3'h2,
        GNP_TM_SLAVE_JITTER = 3'h3,
        GNP_TM_DISTORTION = 3'h4
    } gnp_test_mode_e;

    localparam int GNP_IDLE_CNT_W = 8;

endpackage
`default_nettype wire

/* gnp_idle_cnt.sv */
// saturating idle error counter, cleared by a read of gigabit status
// assumes clr and inc are synchronous one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module gnp_idle_cnt #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic inc,
    input wire logic clr,
    output logic [WIDTH-1:0] count_r
);
    localparam logic [WIDTH-1:0] CNT_MAX = {WIDTH{1'b1}};
    localparam logic [WIDTH-1:0] CNT_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

    logic [WIDTH-1:0] count_nxt;

    // an error in the clearing cycle is counted afresh, never lost
    always_comb begin
        if (clr) begin
            count_nxt = inc ? CNT_ONE : '0;
        end else if (inc && count_r != CNT_MAX) begin
            count_nxt = count_r + CNT_ONE;
        end else begin
            count_nxt = count_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    property p_idle_saturate;
        @(posedge ref_clk) disable iff (!rst_n)
        (count_r == CNT_MAX && inc && !clr) |=> (count_r == CNT_MAX);
    endproperty
    a_idle_saturate: assert property (p_idle_saturate) else $error("idle count wrapped");

    property p_idle_clear;
        @(posedge ref_clk) disable iff (!rst_n)
        clr |=> (count_r == (($past(inc)) ? CNT_ONE : '0));
    endproperty
    a_idle_clear: assert property (p_idle_clear) else $error("idle count not restarted");

    c_idle_full: cover property (@(posedge ref_clk) disable iff (!rst_n) count_r == CNT_MAX && inc);

endmodule // gnp_idle_cnt
`default_nettype wire

/* gnp_regs.sv */
// next-page and gigabit master/slave management registers of a copper gigabit PHY
// assumes a management front end that issues one-cycle read/write strobes with a 5-bit
// address, and a negotiation core that gives synchronous pulses and levels on ref_clk
`timescale 1ns/1ps
`default_nettype none

module gnp_regs (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire gnp_pkg::gnp_addr_t reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire gnp_pkg::gnp_word_t reg_wdata,
    output gnp_pkg::gnp_word_t reg_rdata,
    output logic reg_rvalid,
    input wire logic np_rx_valid,
    input wire gnp_pkg::gnp_word_t np_rx_page,
    input wire logic np_tx_done,
    output gnp_pkg::gnp_word_t np_tx_page,
    output logic [2:0] test_mode,
    output logic ms_manual,
    output logic ms_force_master,
    output logic port_multi,
    output logic adv_gig_full,
    output logic adv_gig_half,
    input wire logic ms_fault,
    input wire logic ms_master,
    input wire logic local_rx_ok,
    input wire logic remote_rx_ok,
    input wire logic partner_gig_full_ability,
    input wire logic partner_gig_half_ability,
    input wire logic idle_err
);
    import gnp_pkg::*;

    logic wr_np_tx;
    logic wr_gctrl;
    logic rd_gstat;

    // outgoing page fields
    logic np_more_r;
    logic np_msg_r;
    logic np_comply_r;
    logic outgoing_page_flip_r;
    logic [GNP_NP_CODE_W-1:0] np_code_r;

    // received page and control
    gnp_word_t partner_np_r;
    gnp_word_t gctrl_r;
    logic [GNP_IDLE_CNT_W-1:0] idle_cnt;
    gnp_word_t rdata_nxt;

    assign wr_np_tx = reg_wr && reg_addr == GNP_OFS_NP_TX;
    assign wr_gctrl = reg_wr && reg_addr == GNP_OFS_GCTRL;
    assign rd_gstat = reg_rd && reg_addr == GNP_OFS_GSTAT;

    function automatic gnp_word_t np_tx_word(input logic more, input logic msg, input logic comply,
                                             input logic flip, input logic [GNP_NP_CODE_W-1:0] code);
        np_tx_word = {more, 1'b0, msg, comply, flip, code};
    endfunction

    // writable fields of the outgoing page; bit 14 is not stored and reads zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            np_more_r <= GNP_RST_NP_TX[GNP_NP_MORE];
            np_msg_r <= GNP_RST_NP_TX[GNP_NP_MSG];
            np_comply_r <= GNP_RST_NP_TX[GNP_NP_COMPLY];
            np_code_r <= GNP_RST_NP_TX[GNP_NP_CODE_W-1:0];
        end else if (wr_np_tx) begin
            np_more_r <= reg_wdata[GNP_NP_MORE];
            np_msg_r <= reg_wdata[GNP_NP_MSG];
            np_comply_r <= reg_wdata[GNP_NP_COMPLY];
            np_code_r <= reg_wdata[GNP_NP_CODE_W-1:0];
        end
    end

    // software cannot touch the flip; it inverts once per completed page exchange
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            outgoing_page_flip_r <= GNP_RST_NP_TX[GNP_NP_FLIP];
        end else if (np_tx_done) begin
            outgoing_page_flip_r <= !outgoing_page_flip_r;
        end
    end

    // partner next pages land here rather than in the base ability register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            partner_np_r <= GNP_RST_NP_RX;
        end else if (np_rx_valid) begin
            partner_np_r <= np_rx_page;
        end
    end

    // reserved low byte is stored as written; software is expected to keep it zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gctrl_r <= GNP_RST_GCTRL;
        end else if (wr_gctrl) begin
            gctrl_r <= reg_wdata;
        end
    end

    // control outputs to the negotiation core
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            test_mode <= GNP_TM_NORMAL;
            ms_manual <= GNP_RST_GCTRL[GNP_GC_MS_MANUAL];
            ms_force_master <= 1'b0;
            port_multi <= GNP_RST_GCTRL[GNP_GC_MULTIPORT];
            adv_gig_full <= GNP_RST_GCTRL[GNP_GC_ADV_FULL];
            adv_gig_half <= GNP_RST_GCTRL[GNP_GC_ADV_HALF];
        end else begin
            // a reserved code would leave the line undefined, so it runs as normal instead
            test_mode <= (gctrl_r[GNP_GC_TEST_HI:GNP_GC_TEST_LO] > GNP_TM_DISTORTION) ?
                         GNP_TM_NORMAL : gctrl_r[GNP_GC_TEST_HI:GNP_GC_TEST_LO];
            ms_manual <= gctrl_r[GNP_GC_MS_MANUAL];
            ms_force_master <= gctrl_r[GNP_GC_MS_MANUAL] && gctrl_r[GNP_GC_MS_MASTER];
            port_multi <= gctrl_r[GNP_GC_MULTIPORT];
            adv_gig_full <= gctrl_r[GNP_GC_ADV_FULL];
            adv_gig_half <= gctrl_r[GNP_GC_ADV_HALF];
        end
    end

    assign np_tx_page = np_tx_word(np_more_r, np_msg_r, np_comply_r, outgoing_page_flip_r, np_code_r);

    gnp_idle_cnt #(
        .WIDTH(GNP_IDLE_CNT_W)
    ) u_idle_cnt (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .inc(idle_err),
        .clr(rd_gstat),
        .count_r(idle_cnt)
    );

    // read mux; unmapped offsets read as zero
    always_comb begin
        case (reg_addr)
            GNP_OFS_NP_TX: rdata_nxt = np_tx_page;
            GNP_OFS_NP_RX: rdata_nxt = partner_np_r;
            GNP_OFS_GCTRL: rdata_nxt = gctrl_r;
            GNP_OFS_GSTAT: rdata_nxt = {ms_fault, ms_master, local_rx_ok, remote_rx_ok,
                                        partner_gig_full_ability, partner_gig_half_ability,
                                        2'h0, idle_cnt};
            GNP_OFS_EXTST: rdata_nxt = GNP_VAL_EXTST;
            default: rdata_nxt = 16'h0000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_nxt;
            end
        end
    end

    property p_np_more;
        @(posedge ref_clk) disable iff (!rst_n)
        wr_np_tx |=> np_tx_page[GNP_NP_MORE] == $past(reg_wdata[GNP_NP_MORE]);
    endproperty
    a_np_more: assert property (p_np_more) else $error("more-pages bit not written");

    property p_np_msg;
        @(posedge ref_clk) disable iff (!rst_n)
        wr_np_tx |=> np_tx_page[GNP_NP_MSG] == $past(reg_wdata[GNP_NP_MSG]) && !np_tx_page[GNP_NP_ACK];
    endproperty
    a_np_msg: assert property (p_np_msg) else $error("message bit wrong");

    property p_np_comply;
        @(posedge ref_clk) disable iff (!rst_n)
        wr_np_tx |=> np_tx_page[GNP_NP_COMPLY] == $past(reg_wdata[GNP_NP_COMPLY]);
    endproperty
    a_np_comply: assert property (p_np_comply) else $error("comply bit wrong");

    property p_np_flip;
        @(posedge ref_clk) disable iff (!rst_n)
        np_tx_done |=> np_tx_page[GNP_NP_FLIP] != $past(np_tx_page[GNP_NP_FLIP]);
    endproperty
    a_np_flip: assert property (p_np_flip) else $error("flip did not invert");

    property p_np_flip_ro;
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_np_tx && !np_tx_done) |=> $stable(np_tx_page[GNP_NP_FLIP]);
    endproperty
    a_np_flip_ro: assert property (p_np_flip_ro) else $error("flip changed by a write");

    property p_np_code;
        @(posedge ref_clk) disable iff (!rst_n)
        wr_np_tx |=> np_tx_page[GNP_NP_CODE_W-1:0] == $past(reg_wdata[GNP_NP_CODE_W-1:0]);
    endproperty
    a_np_code: assert property (p_np_code) else $error("code field wrong");

    property p_rx_store;
        @(posedge ref_clk) disable iff (!rst_n)
        np_rx_valid ##1 !np_rx_valid ##1 (reg_rd && reg_addr == GNP_OFS_NP_RX && !np_rx_valid)
            |=> reg_rvalid && reg_rdata == $past(np_rx_page, 3);
    endproperty
    a_rx_store: assert property (p_rx_store) else $error("partner page not stored");

    property p_test_mode;
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_gctrl && reg_wdata[GNP_GC_TEST_HI:GNP_GC_TEST_LO] <= GNP_TM_DISTORTION) ##1 !wr_gctrl
            |=> test_mode == $past(reg_wdata[GNP_GC_TEST_HI:GNP_GC_TEST_LO], 2);
    endproperty
    a_test_mode: assert property (p_test_mode) else $error("test mode not applied");

    property p_force_ignored;
        @(posedge ref_clk) disable iff (!rst_n)
        !gctrl_r[GNP_GC_MS_MANUAL] |=> !ms_force_master && !ms_manual;
    endproperty
    a_force_ignored: assert property (p_force_ignored) else $error("role forced while automatic");

    property p_adv;
        @(posedge ref_clk) disable iff (!rst_n)
        wr_gctrl ##1 !wr_gctrl |=> adv_gig_full == $past(reg_wdata[GNP_GC_ADV_FULL], 2)
            && adv_gig_half == $past(reg_wdata[GNP_GC_ADV_HALF], 2);
    endproperty
    a_adv: assert property (p_adv) else $error("duplex advertisement wrong");

    property p_status_read;
        @(posedge ref_clk) disable iff (!rst_n)
        rd_gstat |=> reg_rvalid && reg_rdata[15:10] == $past({ms_fault, ms_master, local_rx_ok,
            remote_rx_ok, partner_gig_full_ability, partner_gig_half_ability});
    endproperty
    a_status_read: assert property (p_status_read) else $error("status bits wrong");

    property p_ext_read;
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == GNP_OFS_EXTST) |=> reg_rvalid && reg_rdata == 16'h3000;
    endproperty
    a_ext_read: assert property (p_ext_read) else $error("extended status wrong");

    property p_rx_ro;
        @(posedge ref_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == GNP_OFS_NP_RX && !np_rx_valid) |=> $stable(partner_np_r);
    endproperty
    a_rx_ro: assert property (p_rx_ro) else $error("partner page changed by a write");

    property p_rx_flip;
        @(posedge ref_clk) disable iff (!rst_n)
        np_rx_valid |=> partner_np_r[GNP_NP_FLIP] == $past(np_rx_page[GNP_NP_FLIP]);
    endproperty
    a_rx_flip: assert property (p_rx_flip) else $error("partner flip not kept");

    property p_role_ctrl;
        @(posedge ref_clk) disable iff (!rst_n)
        wr_gctrl ##1 !wr_gctrl |=> ms_manual == $past(reg_wdata[GNP_GC_MS_MANUAL], 2)
            && ms_force_master == ($past(reg_wdata[GNP_GC_MS_MANUAL], 2)
            && $past(reg_wdata[GNP_GC_MS_MASTER], 2));
    endproperty
    a_role_ctrl: assert property (p_role_ctrl) else $error("role control not applied");

    property p_port_type;
        @(posedge ref_clk) disable iff (!rst_n)
        wr_gctrl ##1 !wr_gctrl |=> port_multi == $past(reg_wdata[GNP_GC_MULTIPORT], 2);
    endproperty
    a_port_type: assert property (p_port_type) else $error("port type not applied");

    property p_status_rsvd;
        @(posedge ref_clk) disable iff (!rst_n)
        rd_gstat |=> reg_rdata[9:8] == 2'h0;
    endproperty
    a_status_rsvd: assert property (p_status_rsvd) else $error("status reserved bits set");

    // reset is synchronous, so a single low edge must already load every documented value
    property p_reset_vals;
        @(posedge ref_clk)
        !rst_n |=> np_tx_page == GNP_RST_NP_TX && partner_np_r == GNP_RST_NP_RX && gctrl_r == GNP_RST_GCTRL
            && !reg_rvalid && test_mode == GNP_TM_NORMAL && adv_gig_full && !adv_gig_half;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

    c_page_exchange: cover property (@(posedge ref_clk) disable iff (!rst_n) np_tx_done ##1 np_rx_valid);
    c_manual_master: cover property (@(posedge ref_clk) disable iff (!rst_n) ms_force_master);
    c_status_clear: cover property (@(posedge ref_clk) disable iff (!rst_n) rd_gstat && idle_err);

endmodule // gnp_regs
`default_nettype wire

/* gnp_link_partner.sv */
// remote copper phy model: sends next pages, acknowledges ours, reports idle errors
// assumes one bench process calls its tasks between register accesses
`timescale 1ns/1ps
`default_nettype none
module gnp_link_partner (
    input wire logic ref_clk,
    output logic np_rx_valid,
    output gnp_pkg::gnp_word_t np_rx_page,
    output logic np_tx_done,
    output logic idle_err,
    output logic partner_gig_full_ability,
    output logic partner_gig_half_ability
);
    import gnp_pkg::*;
    logic flip_r = 1'b0;
    initial {np_rx_valid, np_tx_done, idle_err, partner_gig_full_ability, partner_gig_half_ability} = 5'h00;
    initial np_rx_page = 16'hA5C3;
    task automatic send_page(input gnp_word_t page);
        @(negedge ref_clk);
        np_rx_page = {page[15:12], flip_r, page[10:0]};
        np_rx_valid = 1'b1;
        @(negedge ref_clk);
        np_rx_valid = 1'b0;
        // page no longer qualified: show garbage, never the old word
        np_rx_page = ~np_rx_page;
        flip_r = ~flip_r;
    endtask
    // ack=1 pulses the exchange done line, else idle errors, for n cycles back to back
    task automatic strobe(input int n, input bit ack);
        @(negedge ref_clk);
        if (ack) np_tx_done = 1'b1;
        else idle_err = 1'b1;
        repeat (n) @(negedge ref_clk);
        {np_tx_done, idle_err} = 2'b00;
    endtask
    task automatic set_abil(input logic [1:0] ab);
        {partner_gig_full_ability, partner_gig_half_ability} = ab;
    endtask
endmodule // gnp_link_partner
`default_nettype wire

/* gig_copper_nextpage_ms_regs_tb_top.sv */
// self-checking bench of the next-page and gigabit master/slave registers
// assumes gnp_pkg, the register block and the link partner model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module gig_copper_nextpage_ms_regs_tb_top;
    import gnp_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    gnp_addr_t reg_addr = 5'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    gnp_word_t reg_wdata = 16'h0000;
    gnp_word_t reg_rdata, np_rx_page, np_tx_page;
    logic reg_rvalid, np_rx_valid, np_tx_done, idle_err, ms_manual, ms_force_master, port_multi;
    logic adv_gig_full, adv_gig_half, pfull, phalf;
    logic [2:0] test_mode;
    logic [3:0] core_st = 4'h0; // fault, master, local ok, remote ok
    logic [37:0] rows [10]; // addr, write, wdata, expected read
    int errors = 0;
    int n_tests = 0;

    always #12.5 ref_clk = ~ref_clk;

    gnp_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .np_rx_valid(np_rx_valid),
        .np_rx_page(np_rx_page), .np_tx_done(np_tx_done), .np_tx_page(np_tx_page), .test_mode(test_mode),
        .ms_manual(ms_manual), .ms_force_master(ms_force_master), .port_multi(port_multi),
        .adv_gig_full(adv_gig_full), .adv_gig_half(adv_gig_half), .ms_fault(core_st[3]),
        .ms_master(core_st[2]), .local_rx_ok(core_st[1]), .remote_rx_ok(core_st[0]),
        .partner_gig_full_ability(pfull), .partner_gig_half_ability(phalf), .idle_err(idle_err));
    gnp_link_partner lp (.ref_clk(ref_clk), .np_rx_valid(np_rx_valid), .np_rx_page(np_rx_page),
        .np_tx_done(np_tx_done), .idle_err(idle_err), .partner_gig_full_ability(pfull),
        .partner_gig_half_ability(phalf));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic do_reset();
        @(negedge ref_clk);
        rst_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
    endtask
    task automatic wr(input gnp_addr_t a, input gnp_word_t w);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = w;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_wdata = ~w;
    endtask
    // read answer comes a fixed cycle after the strobe and stands one cycle only
    task automatic rdc(input gnp_addr_t a, input gnp_word_t e);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        `CHK(reg_rvalid, 1'b1)
        `CHK(reg_rdata, e)
        @(negedge ref_clk);
        `CHK(reg_rvalid, 1'b0)
    endtask
    task automatic ctl(input gnp_word_t w, input logic [4:0] e);
        wr(GNP_OFS_GCTRL, w);
        @(negedge ref_clk);
        `CHK({ms_manual, ms_force_master, port_multi, adv_gig_full, adv_gig_half}, e)
    endtask

    initial begin
        #1ms;
        errors++;
        end_of_test();
    end

    initial begin
        rows = '{{GNP_OFS_NP_TX, 1'b0, 16'h0000, GNP_RST_NP_TX},
                 {GNP_OFS_NP_RX, 1'b0, 16'h0000, GNP_RST_NP_RX},
                 {GNP_OFS_GCTRL, 1'b0, 16'h0000, GNP_RST_GCTRL},
                 {GNP_OFS_GSTAT, 1'b0, 16'h0000, 16'h0000},
                 {GNP_OFS_EXTST, 1'b0, 16'h0000, 16'h3000},
                 // reserved bits are written as zero; bit 11 ignores the one written to it
                 {GNP_OFS_NP_TX, 1'b1, 16'h9FFF, 16'h97FF},
                 {GNP_OFS_NP_RX, 1'b1, 16'hFFFF, 16'h0000},
                 {GNP_OFS_EXTST, 1'b1, 16'h0000, 16'h3000},
                 {GNP_OFS_GSTAT, 1'b1, 16'hFCFF, 16'h0000},
                 {5'h15, 1'b1, 16'hFFFF, 16'h0000}};
        do_reset();
        foreach (rows[i]) begin
            if (rows[i][32]) wr(rows[i][37:33], rows[i][31:16]);
            rdc(rows[i][37:33], rows[i][15:0]);
        end
        `CHK(np_tx_page, 16'h97FF)
        $display("table test done");
        lp.strobe(1, 1'b1);
        `CHK(np_tx_page, 16'h9FFF)
        lp.strobe(1, 1'b1);
        rdc(GNP_OFS_NP_TX, 16'h97FF);
        lp.send_page(16'hD5AA);
        rdc(GNP_OFS_NP_RX, 16'hD5AA);
        lp.send_page(16'h2155);
        rdc(GNP_OFS_NP_RX, 16'h2955);
        $display("page test done");
        // software never programs the reserved codes 5 to 7
        for (int m = 0; m < 5; m++) begin
            wr(GNP_OFS_GCTRL, {m[2:0], 13'h0200});
            @(negedge ref_clk);
            `CHK(test_mode, m[2:0])
            rdc(GNP_OFS_GCTRL, {m[2:0], 13'h0200});
        end
        ctl(16'h0800, 5'b00000);
        ctl(16'h1800, 5'b11000);
        ctl(16'h0700, 5'b00111);
        $display("control test done");
        core_st = 4'hF;
        lp.set_abil(2'b11);
        lp.strobe(3, 1'b0);
        rdc(GNP_OFS_GSTAT, 16'hFC03);
        rdc(GNP_OFS_GSTAT, 16'hFC00);
        core_st = 4'h5;
        lp.set_abil(2'b10);
        lp.strobe(300, 1'b0);
        rdc(GNP_OFS_GSTAT, 16'h58FF);
        rdc(GNP_OFS_GSTAT, 16'h5800);
        // an error in the clearing cycle is counted afresh
        fork
            lp.strobe(4, 1'b0);
            rdc(GNP_OFS_GSTAT, 16'h5800);
        join
        rdc(GNP_OFS_GSTAT, 16'h5804);
        $display("status test done");
        do_reset();
        `CHK({np_tx_page, test_mode, port_multi, adv_gig_full, adv_gig_half}, {GNP_RST_NP_TX, 6'h02})
        `CHK({reg_rvalid, reg_rdata, ms_manual, ms_force_master}, 19'h00000)
        rdc(GNP_OFS_NP_RX, GNP_RST_NP_RX);
        rdc(GNP_OFS_GCTRL, GNP_RST_GCTRL);
        $display("reset test done");
        end_of_test();
    end
endmodule // gig_copper_nextpage_ms_regs_tb_top
`default_nettype wire
